// File: design/timer_pkg.sv
/*
  shared constants and carrier types for the dual timer/counter block.
  assumes a single 50 MHz clock and an ahb-lite master with word access.
*/
package timer_pkg;

  // system clock and the timer-mode count rate
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_CYCLES = 2;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_FLAGS = 8'h88;
  localparam logic [7:0] IDX_MODE_SELECT = 8'h89;
  localparam logic [7:0] IDX_T0_LOW = 8'h8a;
  localparam logic [7:0] IDX_T1_LOW = 8'h8b;
  localparam logic [7:0] IDX_T0_HIGH = 8'h8c;
  localparam logic [7:0] IDX_T1_HIGH = 8'h8d;

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_PIN_LEVEL = 1'h1;

  // timer mode field encodings
  localparam logic [1:0] MODE_PRESCALE = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [4:0] PRESCALE_MAX = 5'h1f;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef struct packed {
    logic timer1_overflow_flag;
    logic timer1_run;
    logic timer0_overflow_flag;
    logic timer0_run;
    logic ext_irq1_edge_flag;
    logic ext_irq1_trigger_select;
    logic ext_irq0_edge_flag;
    logic ext_irq0_trigger_select;
  } ctrl_flags_t;

  typedef struct packed {
    logic gating;
    logic count_select;
    logic [1:0] mode_field;
  } timer_sel_t;

  typedef struct packed {
    timer_sel_t t1;
    timer_sel_t t0;
  } mode_select_t;

  // interrupt flags out to the core, and the vector acknowledges back
  typedef struct packed {
    logic timer1;
    logic timer0;
    logic ext1;
    logic ext0;
  } irq_flags_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic ovf;
  } step_t;

endpackage

// File: design/pin_sync.sv
/*
  two-flop synchroniser with falling-edge detect for one external pin.
  assumes the pin is asynchronous to hclk and idles high.
*/
`timescale 1ns/100ps
module pin_sync
#(
  parameter logic RESET_LEVEL = 1'h1
)
(
  input wire logic hclk,      // system clock
  input wire logic hresetn,   // async reset, active low
  input wire logic pin_async, // raw pin
  output logic pin_level,     // synchronised level
  output logic pin_fall       // one-cycle pulse on a high-to-low change
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  //////////////////////////////////////////////////////////////////////////
  // first stage is read only by the second one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= RESET_LEVEL;
      sync_reg <= RESET_LEVEL;
      last_reg <= RESET_LEVEL;
    end
    else
    begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign pin_level = sync_reg;
  assign pin_fall = last_reg & ~sync_reg;

endmodule // pin_sync

// File: design/dual_timer.sv
/*
  two timer/counters with run, gating, count-select and four modes, plus
  the two external interrupt inputs that gate them, on an ahb-lite slave.
  assumes the core pulses a vector acknowledge on hclk when it enters the
  matching service routine; pins are asynchronous and idle high.
*/
// Our own choice: the AHB-Lite register port.
// Notes on behaviour
// - timer1 overflow sets flag, vector clears it
// - timer0 overflow sets flag, vector clears it
// - timer1 counts only while its run bit set
// - timer0 counts only while its run bit set
// - irq1 falling edge sets flag, vector clears
// - irq0 falling edge sets flag, vector clears
// - trigger select: 0 low level, 1 falling edge
// - timer1 gating also needs irq1 pin high
// - timer0 gating also needs irq0 pin high
// - timer1 ticks every two clocks or pin fall
// - timer0 ticks every two clocks or pin fall
// - timer1 mode 0: 5-bit prescaler, 8-bit high
// - timer1 mode 1 16-bit, mode 2 reload
// - timer1 mode 3 stops counting
// - timer0 modes 0, 1, 2 as timer1
// - timer0 mode 3 splits bytes, high uses timer1
// - count bytes read/write, reset to zero
`timescale 1ns/100ps
module dual_timer
#(
  parameter int unsigned ADDR_W = 12
)
(
  input wire logic hclk,                    // system clock, 50 MHz
  input wire logic hresetn,                 // async reset, active low
  input wire logic hsel,                    // slave select
  input wire logic [ADDR_W-1:0] haddr,      // byte address
  input wire logic [1:0] htrans,            // transfer type
  input wire logic hwrite,                  // write when high
  input wire logic [2:0] hsize,             // word only
  input wire logic [31:0] hwdata,           // write data
  input wire logic hready,                  // bus ready
  output logic hreadyout,                   // slave ready
  output logic hresp,                       // always okay
  output logic [31:0] hrdata,               // read data
  input wire logic ext_irq0_pin,            // int 0 pin
  input wire logic ext_irq1_pin,            // int 1 pin
  input wire logic timer0_count_pin,        // timer0 count pin
  input wire logic timer1_count_pin,        // timer1 count pin
  input wire timer_pkg::irq_flags_t vec_ack, // vector taken pulses
  output timer_pkg::irq_flags_t irq_flags   // flags to the core
);

  timer_pkg::ctrl_flags_t ctrl_reg, ctrl_next;
  timer_pkg::mode_select_t mode_reg;
  logic [7:0] t0_lo_reg, t0_hi_reg, t1_lo_reg, t1_hi_reg, idx_reg;
  logic [7:0] wbyte, rd_byte;
  logic [31:0] hrdata_reg;
  logic [3:0] pin_raw, pin_level, pin_fall;
  logic wr_en_reg, rd_wait_reg, tick_reg, accept, addr_ok;
  logic src0, src1, en0, en1, inc0, inc1, inc0_hi;
  logic ovf0, ovf1, ovf0_hi, flag1_set, ext0_set, ext1_set;
  timer_pkg::step_t step0, step1;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: irq0, irq1, count0, count1
  assign pin_raw = {timer1_count_pin, timer0_count_pin,
                    ext_irq1_pin, ext_irq0_pin};

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_pin
      pin_sync #(
        .RESET_LEVEL(timer_pkg::RST_PIN_LEVEL)
      ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_async(pin_raw[i]),
        .pin_level(pin_level[i]),
        .pin_fall(pin_fall[i])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite slave; reads add one wait state so hrdata is registered
  assign accept = hsel & hready & (htrans == timer_pkg::HTRANS_NONSEQ);
  assign addr_ok = (haddr[1:0] == 2'h0) &&
                   (haddr[ADDR_W-1:10] == '0);
  assign wbyte = hwdata[7:0];
  assign hreadyout = ~rd_wait_reg;
  assign hresp = timer_pkg::HRESP_OKAY;
  assign hrdata = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idx_reg <= 8'h00;
      wr_en_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
    end
    else
    begin
      if (accept)
        idx_reg <= addr_ok ? haddr[9:2] : 8'h00;
      wr_en_reg <= accept & hwrite;
      rd_wait_reg <= accept & ~hwrite;
    end
  end

  // unmapped indices read as zero
  always_comb
  begin
    case (idx_reg)
      timer_pkg::IDX_CTRL_FLAGS: rd_byte = ctrl_reg;
      timer_pkg::IDX_MODE_SELECT: rd_byte = mode_reg;
      timer_pkg::IDX_T0_LOW: rd_byte = t0_lo_reg;
      timer_pkg::IDX_T1_LOW: rd_byte = t1_lo_reg;
      timer_pkg::IDX_T0_HIGH: rd_byte = t0_hi_reg;
      timer_pkg::IDX_T1_HIGH: rd_byte = t1_hi_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= 32'h0000_0000;
    else if (rd_wait_reg)
      hrdata_reg <= {24'h00_0000, rd_byte};
  end

  //////////////////////////////////////////////////////////////////////////
  // count sources and enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tick_reg <= 1'b0;
    else
      tick_reg <= ~tick_reg;
  end

  assign src0 = mode_reg.t0.count_select ? pin_fall[2] : tick_reg;
  assign src1 = mode_reg.t1.count_select ? pin_fall[3] : tick_reg;
  assign en0 = ctrl_reg.timer0_run &
               (~mode_reg.t0.gating | pin_level[0]);
  assign en1 = ctrl_reg.timer1_run &
               (~mode_reg.t1.gating | pin_level[1]);
  assign inc0 = en0 & src0;
  assign inc1 = en1 & src1 &
                (mode_reg.t1.mode_field != timer_pkg::MODE_SPLIT);
  // split high byte runs on the machine rate under timer1's run bit
  assign inc0_hi = (mode_reg.t0.mode_field == timer_pkg::MODE_SPLIT) &
                   ctrl_reg.timer1_run & tick_reg;

  // one increment of a timer in the given mode
  function automatic timer_pkg::step_t count_step(
    input logic [1:0] mode,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    timer_pkg::step_t r;
    r.lo = lo;
    r.hi = hi;
    r.ovf = 1'b0;
    case (mode)
      timer_pkg::MODE_PRESCALE:
      begin
        r.lo = {lo[7:5], lo[4:0] + 5'h01};
        if (lo[4:0] == timer_pkg::PRESCALE_MAX)
        begin
          r.hi = hi + 8'h01;
          r.ovf = (hi == 8'hff);
        end
      end
      timer_pkg::MODE_16BIT:
      begin
        {r.hi, r.lo} = {hi, lo} + 16'h0001;
        r.ovf = ({hi, lo} == 16'hffff);
      end
      timer_pkg::MODE_RELOAD:
      begin
        r.ovf = (lo == 8'hff);
        r.lo = r.ovf ? hi : lo + 8'h01;
      end
      default:
      begin
        r.lo = lo + 8'h01;
        r.ovf = (lo == 8'hff);
      end
    endcase
    return r;
  endfunction

  assign step0 = count_step(mode_reg.t0.mode_field, t0_lo_reg, t0_hi_reg);
  assign step1 = count_step(mode_reg.t1.mode_field, t1_lo_reg, t1_hi_reg);
  assign ovf0 = inc0 & step0.ovf;
  assign ovf1 = inc1 & step1.ovf;
  assign ovf0_hi = inc0_hi & (t0_hi_reg == 8'hff);

  //////////////////////////////////////////////////////////////////////////
  // count bytes; a software write wins over a count in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      t0_lo_reg <= timer_pkg::RST_BYTE;
      t0_hi_reg <= timer_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_en_reg && idx_reg == timer_pkg::IDX_T0_LOW)
        t0_lo_reg <= wbyte;
      else if (inc0)
        t0_lo_reg <= step0.lo;
      if (wr_en_reg && idx_reg == timer_pkg::IDX_T0_HIGH)
        t0_hi_reg <= wbyte;
      else if (inc0_hi)
        t0_hi_reg <= t0_hi_reg + 8'h01;
      else if (inc0 && mode_reg.t0.mode_field != timer_pkg::MODE_SPLIT)
        t0_hi_reg <= step0.hi;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      t1_lo_reg <= timer_pkg::RST_BYTE;
      t1_hi_reg <= timer_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_en_reg && idx_reg == timer_pkg::IDX_T1_LOW)
        t1_lo_reg <= wbyte;
      else if (inc1)
        t1_lo_reg <= step1.lo;
      if (wr_en_reg && idx_reg == timer_pkg::IDX_T1_HIGH)
        t1_hi_reg <= wbyte;
      else if (inc1)
        t1_hi_reg <= step1.hi;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode_reg <= timer_pkg::RST_BYTE;
    else if (wr_en_reg && idx_reg == timer_pkg::IDX_MODE_SELECT)
      mode_reg <= wbyte;
  end

  //////////////////////////////////////////////////////////////////////////
  // control flags: hardware set beats both software write and vector clear
  // timer1 loses its flag to the split high byte while timer0 is split
  assign flag1_set = (mode_reg.t0.mode_field == timer_pkg::MODE_SPLIT) ?
                     ovf0_hi : ovf1;
  assign ext0_set = ctrl_reg.ext_irq0_trigger_select ?
                    pin_fall[0] : ~pin_level[0];
  assign ext1_set = ctrl_reg.ext_irq1_trigger_select ?
                    pin_fall[1] : ~pin_level[1];

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_en_reg && idx_reg == timer_pkg::IDX_CTRL_FLAGS)
      ctrl_next = wbyte;
    if (vec_ack.timer1)
      ctrl_next.timer1_overflow_flag = 1'b0;
    if (vec_ack.timer0)
      ctrl_next.timer0_overflow_flag = 1'b0;
    if (vec_ack.ext1)
      ctrl_next.ext_irq1_edge_flag = 1'b0;
    if (vec_ack.ext0)
      ctrl_next.ext_irq0_edge_flag = 1'b0;
    if (flag1_set)
      ctrl_next.timer1_overflow_flag = 1'b1;
    if (ovf0)
      ctrl_next.timer0_overflow_flag = 1'b1;
    if (ext1_set)
      ctrl_next.ext_irq1_edge_flag = 1'b1;
    if (ext0_set)
      ctrl_next.ext_irq0_edge_flag = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_reg <= timer_pkg::RST_BYTE;
    else
      ctrl_reg <= ctrl_next;
  end

  assign irq_flags = {ctrl_reg.timer1_overflow_flag,
                      ctrl_reg.timer0_overflow_flag,
                      ctrl_reg.ext_irq1_edge_flag,
                      ctrl_reg.ext_irq0_edge_flag};

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_t0_free;
    (ctrl_reg.timer0_run && !mode_reg.t0.gating &&
     !mode_reg.t0.count_select && !wr_en_reg &&
     mode_reg.t0.mode_field == timer_pkg::MODE_16BIT)[*2];
  endsequence

  a_timer1_flag_set: assert property (
    flag1_set |=> ctrl_reg.timer1_overflow_flag)
    else $error("timer1 flag not set on overflow");
  a_timer0_flag_set: assert property (
    ovf0 |=> ctrl_reg.timer0_overflow_flag)
    else $error("timer0 flag not set on overflow");
  a_timer0_vec_clear: assert property (vec_ack.timer0 && !ovf0 |=>
    !ctrl_reg.timer0_overflow_flag)
    else $error("timer0 flag not cleared by vector");
  a_t1_hold_stop: assert property (!ctrl_reg.timer1_run && !wr_en_reg
    |=> $stable(t1_lo_reg) && $stable(t1_hi_reg))
    else $error("timer1 moved while stopped");
  a_t0_hold_stop: assert property (!ctrl_reg.timer0_run && !wr_en_reg &&
    mode_reg.t0.mode_field != timer_pkg::MODE_SPLIT
    |=> $stable({t0_hi_reg, t0_lo_reg}))
    else $error("timer0 moved while stopped");
  a_ext1_edge: assert property (ctrl_reg.ext_irq1_trigger_select &&
    pin_fall[1] |=> ctrl_reg.ext_irq1_edge_flag)
    else $error("irq1 edge flag missed");
  a_ext0_edge: assert property (ctrl_reg.ext_irq0_trigger_select &&
    pin_fall[0] |=> ctrl_reg.ext_irq0_edge_flag)
    else $error("irq0 edge flag missed");
  a_ext0_level: assert property (
    !ctrl_reg.ext_irq0_trigger_select && !pin_level[0] && !wr_en_reg
    |=> ctrl_reg.ext_irq0_edge_flag)
    else $error("irq0 level flag missed");
  a_gating1_block: assert property (
    mode_reg.t1.gating && !pin_level[1] |-> !en1)
    else $error("timer1 ran with gate low");
  a_gating0_block: assert property (
    mode_reg.t0.gating && !pin_level[0] |-> !inc0)
    else $error("timer0 ran with gate low");
  a_t1_pin_count: assert property (en1 && mode_reg.t1.count_select &&
    !pin_fall[3] |-> !inc1)
    else $error("timer1 counted without pin edge");
  a_t0_half_rate: assert property (s_t0_free |=>
    ({t0_hi_reg, t0_lo_reg} - $past({t0_hi_reg, t0_lo_reg}, 2)) == 16'h0001)
    else $error("timer0 rate not one per two clocks");
  a_t1_prescale: assert property (inc1 && !wr_en_reg &&
    mode_reg.t1.mode_field == timer_pkg::MODE_PRESCALE &&
    t1_lo_reg[4:0] == timer_pkg::PRESCALE_MAX
    |=> t1_hi_reg == $past(t1_hi_reg) + 8'h01 && t1_lo_reg[4:0] == 5'h00)
    else $error("timer1 prescaler carry wrong");
  a_t1_reload: assert property (ovf1 && !wr_en_reg &&
    mode_reg.t1.mode_field == timer_pkg::MODE_RELOAD
    |=> t1_lo_reg == $past(t1_hi_reg))
    else $error("timer1 reload wrong");
  a_t1_mode3_stop: assert property (
    mode_reg.t1.mode_field == timer_pkg::MODE_SPLIT |-> !inc1 && !ovf1)
    else $error("timer1 counted in mode 3");
  a_t0_split_hi: assert property (inc0_hi && !wr_en_reg
    |=> t0_hi_reg == $past(t0_hi_reg) + 8'h01)
    else $error("split high byte did not count");
  a_byte_write: assert property (wr_en_reg &&
    idx_reg == timer_pkg::IDX_T0_LOW |=> t0_lo_reg == $past(wbyte))
    else $error("timer0 low byte write lost");
  a_ovf_wrap: assert property (ovf0 && !wr_en_reg &&
    mode_reg.t0.mode_field == timer_pkg::MODE_16BIT
    |=> {t0_hi_reg, t0_lo_reg} == 16'h0000)
    else $error("overflow without wrap to zero");
  a_read_wait: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule // dual_timer

// File: testbench/ext_pin_model.sv
/*
  behavioural model of the external pins: two interrupt pins and two
  count pins. assumes hclk from the bench; every pin idles high.
*/
`timescale 1ns/100ps
module ext_pin_model
(
  input wire logic hclk,         // system clock
  output logic ext_irq0_pin,     // int 0 pin
  output logic ext_irq1_pin,     // int 1 pin
  output logic timer0_count_pin, // timer0 count pin
  output logic timer1_count_pin  // timer1 count pin
);
  // index order: 0 irq0, 1 irq1, 2 timer0 count, 3 timer1 count
  logic [3:0] pins = 4'hf;

  assign {timer1_count_pin, timer0_count_pin} = pins[3:2];
  assign {ext_irq1_pin, ext_irq0_pin} = pins[1:0];

  task automatic set_pin(input int idx, input logic lvl);
    @(posedge hclk);
    pins[idx] <= lvl;
  endtask

  // four clocks per level, four times the shortest pulse the sync accepts
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      set_pin(idx, 1'b0);
      repeat (3) @(posedge hclk);
      set_pin(idx, 1'b1);
      repeat (3) @(posedge hclk);
    end
  endtask
endmodule // ext_pin_model

// File: testbench/dual_timer_tb.sv
/*
  self-checking bench for the dual timer: ahb-lite register access,
  timer and counter modes, gating and external interrupt flags.
  assumes the design's hready is fed from its own hreadyout.
*/
`timescale 1ns/100ps
module dual_timer_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic ext_irq0_pin, ext_irq1_pin, timer0_count_pin, timer1_count_pin;
  timer_pkg::irq_flags_t vec_ack = 4'h0;
  timer_pkg::irq_flags_t irq_flags;
  int errors = 0;
  int cmp_count = 0;

  dual_timer dual_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ext_irq0_pin(ext_irq0_pin),
    .ext_irq1_pin(ext_irq1_pin), .timer0_count_pin(timer0_count_pin),
    .timer1_count_pin(timer1_count_pin), .vec_ack(vec_ack),
    .irq_flags(irq_flags));

  ext_pin_model ext_pin_model_i (.hclk(hclk), .ext_irq0_pin(ext_irq0_pin),
    .ext_irq1_pin(ext_irq1_pin), .timer0_count_pin(timer0_count_pin),
    .timer1_count_pin(timer1_count_pin));

  initial
  begin
    forever #10 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; returns at the edge that ends it
  task automatic bus(input logic [7:0] idx, input logic wr,
                     input logic [7:0] wd, output logic [7:0] rd);
    hsel <= 1'b1;
    haddr <= {2'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= timer_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(idx, 1'b1, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(idx, 1'b0, 8'h00, x);
    check({24'h0, x}, {24'h0, exp});
  endtask

  // bounded wait for one flag; n counts the edges it took
  task automatic wait_flag(input int b, output int n);
    n = 0;
    while (irq_flags[b] !== 1'b1 && n < 200)
    begin
      @(posedge hclk);
      n++;
    end
  endtask

  // one-cycle vector pulse, then time for the flag to settle
  task automatic ack(input logic [3:0] m);
    vec_ack <= m;
    @(posedge hclk);
    vec_ack <= 4'h0;
    repeat (3) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 6; i++)
      rd_chk(8'h88 + 8'(i), timer_pkg::RST_BYTE);
    check({31'h0, hresp}, {31'h0, timer_pkg::HRESP_OKAY});
    wr(8'h8e, 8'h5a);
    rd_chk(8'h8e, 8'h00);
    for (int i = 2; i < 6; i++)
      wr(8'h88 + 8'(i), 8'ha0 + 8'(i));
    for (int i = 2; i < 6; i++)
      rd_chk(8'h88 + 8'(i), 8'ha0 + 8'(i));
  endtask

  task automatic t_16bit();
    int n;
    wr(timer_pkg::IDX_T0_LOW, 8'hf8);
    wr(timer_pkg::IDX_T0_HIGH, 8'hff);
    wr(timer_pkg::IDX_MODE_SELECT, 8'h01);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h10);
    wait_flag(2, n);
    check(32'(n >= 14 && n <= 19), 32'h1);
    ack(4'h4);
    check({28'h0, irq_flags}, 32'h0);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h00);
    rd_chk(timer_pkg::IDX_T0_HIGH, 8'h00);
  endtask

  task automatic t_reload();
    int n;
    wr(timer_pkg::IDX_T1_HIGH, 8'hf0);
    wr(timer_pkg::IDX_T1_LOW, 8'hfe);
    wr(timer_pkg::IDX_MODE_SELECT, 8'h20);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h40);
    wait_flag(3, n);
    check(32'(n <= 10), 32'h1);
    ack(4'h8);
    check({28'h0, irq_flags}, 32'h0);
    // reload from f0 gives sixteen ticks to the next wrap
    wait_flag(3, n);
    check(32'(n >= 22 && n <= 34), 32'h1);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h00);
    rd_chk(timer_pkg::IDX_T1_HIGH, 8'hf0);
  endtask

  task automatic t_counter();
    wr(timer_pkg::IDX_T0_LOW, 8'h00);
    wr(timer_pkg::IDX_T1_LOW, 8'h00);
    wr(timer_pkg::IDX_MODE_SELECT, 8'h75);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h50);
    ext_pin_model_i.pulse(2, 5);
    ext_pin_model_i.pulse(3, 3);
    repeat (6) @(posedge hclk);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h00);
    rd_chk(timer_pkg::IDX_T0_LOW, 8'h05);
    rd_chk(timer_pkg::IDX_T1_LOW, 8'h00);
    wr(timer_pkg::IDX_MODE_SELECT, 8'h55);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h40);
    ext_pin_model_i.pulse(3, 3);
    ext_pin_model_i.pulse(2, 1);
    repeat (6) @(posedge hclk);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h00);
    rd_chk(timer_pkg::IDX_T1_LOW, 8'h03);
    rd_chk(timer_pkg::IDX_T0_LOW, 8'h05);
  endtask

  task automatic t_gate();
    logic [7:0] x;
    wr(timer_pkg::IDX_T0_LOW, 8'h00);
    wr(timer_pkg::IDX_T1_LOW, 8'h00);
    wr(timer_pkg::IDX_MODE_SELECT, 8'h99);
    ext_pin_model_i.set_pin(0, 1'b0);
    ext_pin_model_i.set_pin(1, 1'b0);
    repeat (6) @(posedge hclk);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h55);
    repeat (20) @(posedge hclk);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h05);
    rd_chk(timer_pkg::IDX_T0_LOW, 8'h00);
    rd_chk(timer_pkg::IDX_T1_LOW, 8'h00);
    ext_pin_model_i.set_pin(0, 1'b1);
    ext_pin_model_i.set_pin(1, 1'b1);
    repeat (6) @(posedge hclk);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h55);
    repeat (20) @(posedge hclk);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h05);
    bus(timer_pkg::IDX_T0_LOW, 1'b0, 8'h00, x);
    check(32'(x >= 8'h09 && x <= 8'h0d), 32'h1);
    bus(timer_pkg::IDX_T1_LOW, 1'b0, 8'h00, x);
    check(32'(x >= 8'h09 && x <= 8'h0d), 32'h1);
  endtask

  task automatic t_ext();
    ext_pin_model_i.pulse(0, 1);
    check({28'h0, irq_flags}, 32'h1);
    ack(4'h1);
    ext_pin_model_i.pulse(1, 1);
    check({28'h0, irq_flags}, 32'h2);
    ack(4'h2);
    check({28'h0, irq_flags}, 32'h0);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h00);
    ext_pin_model_i.set_pin(1, 1'b0);
    repeat (6) @(posedge hclk);
    ack(4'h2);
    check({28'h0, irq_flags}, 32'h2);
    ext_pin_model_i.set_pin(1, 1'b1);
    repeat (6) @(posedge hclk);
    ack(4'h2);
    check({28'h0, irq_flags}, 32'h0);
  endtask

  task automatic t_modes();
    int n;
    logic [7:0] x;
    wr(timer_pkg::IDX_T0_LOW, 8'hfe);
    wr(timer_pkg::IDX_T0_HIGH, 8'h00);
    wr(timer_pkg::IDX_T1_LOW, 8'hfe);
    wr(timer_pkg::IDX_T1_HIGH, 8'h00);
    wr(timer_pkg::IDX_MODE_SELECT, 8'h00);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h50);
    repeat (6) @(posedge hclk);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h00);
    rd_chk(timer_pkg::IDX_T0_HIGH, 8'h01);
    rd_chk(timer_pkg::IDX_T1_HIGH, 8'h01);
    bus(timer_pkg::IDX_T0_LOW, 1'b0, 8'h00, x);
    check({29'h0, x[7:5]}, 32'h7);
    wr(timer_pkg::IDX_T0_LOW, 8'h40);
    wr(timer_pkg::IDX_T0_HIGH, 8'hfc);
    wr(timer_pkg::IDX_MODE_SELECT, 8'h03);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h40);
    wait_flag(3, n);
    check(32'(n <= 12), 32'h1);
    check({31'h0, irq_flags[2]}, 32'h0);
    wr(timer_pkg::IDX_CTRL_FLAGS, 8'h00);
    rd_chk(timer_pkg::IDX_T0_LOW, 8'h40);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge hclk);
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_16bit();
    t_reload();
    t_counter();
    t_gate();
    t_ext();
    t_modes();
    end_sim();
  end
endmodule // dual_timer_tb
